// ===== common/clkbuz_pkg.sv
`default_nettype none
package clkbuz_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [15:0] PORT0_DIR_ADDR = 16'hFF20;
  localparam logic [15:0] SELECT_ADDR    = 16'hFF40;
  localparam logic [15:0] STATUS_ADDR    = 16'hFF44;

  // Reset values
  localparam logic [7:0]  PORT0_DIR_RESET = 8'hFF;
  localparam logic [7:0]  SELECT_RESET    = 8'h00;

  // Direction bits 7:6 are fixed at one
  localparam logic [7:0]  DIR_FIXED_MASK  = 8'hC0;
  // Port-0 bit shared with the clock and buzzer outputs
  localparam int          SHARED_PIN_BIT  = 5;

  // ****************************************
  // Divider taps
  // ****************************************
  localparam logic [3:0]  CO_SEL_FX       = 4'h0;
  localparam logic [3:0]  CO_SEL_MAX_DIV  = 4'h7;
  localparam logic [3:0]  CO_SEL_SUB      = 4'h8;
  // Counter bit that toggles at main_clock / 2^10
  localparam logic [3:0]  BZ_TAP_BASE     = 4'h9;
  localparam int          CO_CNT_W        = 7;
  localparam int          BZ_CNT_W        = 13;

  // Select register layout, bit 7 down to bit 0
  typedef struct packed {
    logic       buzzer_enable;
    logic [1:0] buzzer_freq_sel;
    logic       clock_out_enable;
    logic [3:0] clock_out_sel;
  } select_t;

  // APB request and answer bundles
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [15:0] paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
  } apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } apb_rsp_t;

endpackage
`default_nettype wire

// ===== hw/sub_clock_sync.sv
`timescale 1ns/1ps
`default_nettype none
module sub_clock_sync (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Asynchronous level in, filtered level out
  input  wire logic async_in,
  output logic      level_r
);

  logic s1_r;
  logic s2_r;
  logic s3_r;

  // Three-stage chain, level taken once stages two and three agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_r    <= 1'b0;
      s2_r    <= 1'b0;
      s3_r    <= 1'b0;
      level_r <= 1'b0;
    end else begin
      s1_r <= async_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        level_r <= s3_r;
      end
    end
  end

endmodule // sub_clock_sync
`default_nettype wire

// ===== hw/glitchless_gate.sv
`timescale 1ns/1ps
`default_nettype none
module glitchless_gate (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Enable request and next tap level
  input  wire logic req,
  input  wire logic tap_nxt,
  // Gated output and gate state
  output logic      out_r,
  output logic      active_r
);

  logic active_nxt;

  // Gate may only change while the tap is low: no runt pulses
  assign active_nxt = tap_nxt ? active_r : req;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_r <= 1'b0;
      out_r    <= 1'b0;
    end else begin
      active_r <= active_nxt;
      out_r    <= active_nxt & tap_nxt;
    end
  end

endmodule // glitchless_gate
`default_nettype wire

// ===== hw/clock_and_buzzer_output.sv
// Design decision made here: register access over APB.
`timescale 1ns/1ps
`default_nettype none
module clock_and_buzzer_output
  import clkbuz_pkg::*;
(
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // APB slave
  input  wire apb_req_t   apb_req,
  output apb_rsp_t        apb_rsp,
  // Subsystem clock pin
  input  wire logic       sub_clock,
  // Port-0 output latch of the shared pin
  input  wire logic       port0_latch5,
  // Port-0 buffers, enable low while driving
  output logic [5:0]      port0_output_en_n,
  // Shared pin drive
  output logic            shared_port_pin_o,
  output logic            shared_port_pin_oe_n,
  // Internal views of the two outputs
  output logic            clock_out_pin,
  output logic            buzzer_pin
);

  // ****************************************
  // Register file
  // ****************************************
  logic [7:0]  select_raw_r;
  logic [7:0]  port0_dir_r;
  logic [31:0] prdata_r;
  select_t     cfg;

  logic        hit_dir;
  logic        hit_sel;
  logic        hit_stat;
  logic        hit_any;
  logic        setup_ph;
  logic        wr_acc;
  logic [7:0]  rd_byte;
  logic [7:0]  status_w;

  logic        co_active;
  logic        bz_active;
  logic        co_out_r;
  logic        bz_out_r;
  logic        fx_gate_r;

  assign cfg = select_t'(select_raw_r);

  // Address decode
  assign hit_dir  = (apb_req.paddr == PORT0_DIR_ADDR);
  assign hit_sel  = (apb_req.paddr == SELECT_ADDR);
  assign hit_stat = (apb_req.paddr == STATUS_ADDR);
  assign hit_any  = hit_dir | hit_sel | hit_stat;
  assign setup_ph = apb_req.psel & ~apb_req.penable;
  assign wr_acc   = apb_req.psel & apb_req.penable & apb_req.pwrite & apb_req.pstrb[0];

  // Read mux, status shows the live gate states
  assign status_w = {6'h00, bz_active, co_active | fx_gate_r};
  assign rd_byte  = hit_dir  ? port0_dir_r  :
                    hit_sel  ? select_raw_r :
                    hit_stat ? status_w     : 8'h00;

  // Zero-wait answer, error on unmapped address
  always_comb begin
    apb_rsp.prdata  = prdata_r;
    apb_rsp.pready  = 1'b1;
    apb_rsp.pslverr = apb_req.psel & apb_req.penable & ~hit_any;
  end

  // Read data captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
    end else if (setup_ph) begin
      prdata_r <= {24'h00_0000, rd_byte};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      select_raw_r <= SELECT_RESET;
    end else if (wr_acc && hit_sel) begin
      select_raw_r <= apb_req.pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port0_dir_r <= PORT0_DIR_RESET;
    end else if (wr_acc && hit_dir) begin
      port0_dir_r <= apb_req.pwdata[7:0] | DIR_FIXED_MASK;
    end
  end

  // ****************************************
  // Dividers
  // ****************************************
  logic [CO_CNT_W-1:0] co_cnt_r;
  logic [CO_CNT_W-1:0] co_cnt_nxt;
  logic [BZ_CNT_W-1:0] bz_cnt_r;
  logic [BZ_CNT_W-1:0] bz_cnt_nxt;
  logic                co_run;
  logic                bz_run;
  logic                co_is_div;
  logic [2:0]          co_idx;
  logic [3:0]          bz_idx;
  logic                co_tap_nxt;
  logic                bz_tap_nxt;
  logic                sub_lvl;

  // counters run only while requested or gate open
  assign co_run     = cfg.clock_out_enable | co_active;
  assign bz_run     = cfg.buzzer_enable | bz_active;
  assign co_cnt_nxt = co_run ? co_cnt_r + 1'b1 : '0;
  assign bz_cnt_nxt = bz_run ? bz_cnt_r + 1'b1 : '0;

  // clock tap, bit k-1 gives divide by 2^k
  assign co_is_div  = (cfg.clock_out_sel != CO_SEL_FX) &&
                      (cfg.clock_out_sel <= CO_SEL_MAX_DIV);
  assign co_idx     = 3'(cfg.clock_out_sel - 4'h1);
  assign co_tap_nxt = co_is_div ? co_cnt_nxt[co_idx] :
                      (cfg.clock_out_sel == CO_SEL_SUB) ? sub_lvl : 1'b0;

  // buzzer tap, bit 9 to 12
  assign bz_idx     = BZ_TAP_BASE + {2'b00, cfg.buzzer_freq_sel};
  assign bz_tap_nxt = bz_cnt_nxt[bz_idx];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      co_cnt_r <= '0;
      bz_cnt_r <= '0;
    end else begin
      co_cnt_r <= co_cnt_nxt;
      bz_cnt_r <= bz_cnt_nxt;
    end
  end

  // Subsystem clock arrives from a pin
  sub_clock_sync u_sub_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (sub_clock),
    .level_r  (sub_lvl)
  );

  // ****************************************
  // Glitch-free gating
  // ****************************************
  // clock output gate
  glitchless_gate u_co_gate (
    .pclk     (pclk),
    .presetn  (presetn),
    .req      (cfg.clock_out_enable),
    .tap_nxt  (co_tap_nxt),
    .out_r    (co_out_r),
    .active_r (co_active)
  );

  glitchless_gate u_bz_gate (
    .pclk     (pclk),
    .presetn  (presetn),
    .req      (cfg.buzzer_enable),
    .tap_nxt  (bz_tap_nxt),
    .out_r    (bz_out_r),
    .active_r (bz_active)
  );

  // full-rate gate changes only while the clock is low
  always_ff @(negedge pclk or negedge presetn) begin
    if (!presetn) begin
      fx_gate_r <= 1'b0;
    end else begin
      fx_gate_r <= co_active & (cfg.clock_out_sel == CO_SEL_FX);
    end
  end

  // ****************************************
  // Pins
  // ****************************************
  // selected clock and buzzer square wave
  assign clock_out_pin = (cfg.clock_out_sel == CO_SEL_FX) ? (pclk & fx_gate_r) : co_out_r;
  assign buzzer_pin    = bz_out_r;

  // direction zero turns the buffer on
  assign port0_output_en_n    = port0_dir_r[5:0];
  assign shared_port_pin_oe_n = port0_dir_r[SHARED_PIN_BIT];
  // outputs merge with the port latch, which software keeps low
  assign shared_port_pin_o    = port0_latch5 | clock_out_pin | buzzer_pin;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic [BZ_CNT_W-1:0] bz_mask;
  logic [CO_CNT_W-1:0] co_mask;
  assign bz_mask = (13'h0001 << bz_idx) - 13'h0001;
  assign co_mask = (7'h01 << co_idx) - 7'h01;

  sequence s_co_open;
    $rose(co_active);
  endsequence

  sequence s_co_close;
    $fell(co_active);
  endsequence

  property p_bz_low;
    !cfg.buzzer_enable && !bz_active |=> !buzzer_pin && bz_cnt_r == 13'h0000;
  endproperty
  a_bz_low: assert property (p_bz_low) else $error("buzzer high while gate closed");

  property p_bz_freq;
    $changed(bz_out_r) && bz_active && $past(bz_active) && $stable(cfg.buzzer_freq_sel)
      |-> (bz_cnt_r & bz_mask) == 13'h0000;
  endproperty
  a_bz_freq: assert property (p_bz_freq) else $error("buzzer edge off tap");

  property p_co_low;
    !cfg.clock_out_enable && !co_active && !fx_gate_r |=> !clock_out_pin && co_cnt_r == 7'h00;
  endproperty
  a_co_low: assert property (p_co_low) else $error("clock out high while gate closed");

  property p_co_freq;
    $changed(co_out_r) && co_active && $past(co_active) && co_is_div && $stable(cfg)
      |-> (co_cnt_r & co_mask) == 7'h00;
  endproperty
  a_co_freq: assert property (p_co_freq) else $error("clock out edge off tap");

  property p_co_start;
    s_co_open |-> !co_out_r;
  endproperty
  a_co_start: assert property (p_co_start) else $error("clock out began high");

  property p_co_stop;
    s_co_close |-> !co_out_r && !$past(co_tap_nxt);
  endproperty
  a_co_stop: assert property (p_co_stop) else $error("clock out cut in high phase");

  property p_sel_write;
    wr_acc && hit_sel |=> select_raw_r == $past(apb_req.pwdata[7:0]);
  endproperty
  a_sel_write: assert property (p_sel_write) else $error("select write lost");

  property p_dir_fixed;
    wr_acc && hit_dir |=> port0_dir_r[7:6] == 2'b11 ##1 port0_dir_r[7:6] == 2'b11;
  endproperty
  a_dir_fixed: assert property (p_dir_fixed) else $error("direction top bits cleared");

  property p_pin_drive;
    $fell(port0_dir_r[SHARED_PIN_BIT]) |-> !shared_port_pin_oe_n && !port0_output_en_n[5];
  endproperty
  a_pin_drive: assert property (p_pin_drive) else $error("shared pin not driven");

endmodule // clock_and_buzzer_output
`default_nettype wire

// ===== tb/clkbuz_partner.sv
`timescale 1ns/1ps
`default_nettype none
module clkbuz_partner #(
  parameter int SUB_HALF_NS = 15300
) (
  // Pin driven by the peripheral
  input  wire logic   pin,
  // Subsystem oscillator and pin measurements
  output logic        sub_clock,
  output logic [15:0] edges,
  output logic [31:0] period_ns,
  output logic [31:0] high_ns
);
  realtime t_rise;

  initial begin
    sub_clock = 1'h0;
    forever #(SUB_HALF_NS) sub_clock = ~sub_clock;
  end

  // Start with empty measurements
  initial begin
    edges = 16'h0000;
    t_rise = 0.0;
  end

  always @(posedge pin) begin
    period_ns = 32'($rtoi($realtime - t_rise));
    t_rise = $realtime;
    edges = edges + 16'h0001;
  end

  // Width of the last high phase
  always @(negedge pin) begin
    high_ns = 32'($rtoi($realtime - t_rise));
  end
endmodule // clkbuz_partner
`default_nettype wire

// ===== tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import clkbuz_pkg::*;
  logic        pclk, presetn, latch5, err, sub_clock;
  logic        pin_o, pin_oe_n, co_pin, bz_pin;
  apb_req_t    req;
  apb_rsp_t    rsp;
  logic [5:0]  p0_en_n;
  logic [15:0] edges;
  logic [31:0] period_ns, high_ns, rd;
  int          num_errors, total_checks;

  clock_and_buzzer_output clock_and_buzzer_output_i (
    .pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
    .sub_clock(sub_clock), .port0_latch5(latch5), .port0_output_en_n(p0_en_n),
    .shared_port_pin_o(pin_o), .shared_port_pin_oe_n(pin_oe_n),
    .clock_out_pin(co_pin), .buzzer_pin(bz_pin)
  );

  clkbuz_partner clkbuz_partner_i (
    .pin(pin_o), .sub_clock(sub_clock), .edges(edges),
    .period_ns(period_ns), .high_ns(high_ns)
  );

  // ****************************************
  // Tasks
  // ****************************************
  task check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer, held until pready
  task xfer(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(posedge pclk);
    req <= '{1'h1, 1'h0, w, a, {24'h000000, d}, 4'hF};
    @(posedge pclk);
    req.penable <= 1'h1;
    do @(posedge pclk); while (rsp.pready !== 1'h1);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
  endtask

  // Program, enable, measure, disable, see the pin low
  task run(input logic [7:0] sel, input logic [31:0] per);
    int i;
    logic [15:0] n0;
    xfer(1'h1, SELECT_ADDR, sel & 8'h6F);
    xfer(1'h1, SELECT_ADDR, sel);
    n0 = edges;
    for (i = 0; i < 4 * per / 100 + 20 && edges - n0 < 16'h0003; i++) @(posedge pclk);
    check(period_ns, per);
    check(high_ns, per >> 1);
    xfer(1'h0, STATUS_ADDR, 8'h00);
    check(rd, {30'h0, sel[7], sel[4]});
    xfer(1'h1, SELECT_ADDR, sel & 8'h6F);
    repeat (per / 100 + 20) @(posedge pclk);
    check({31'h0, pin_o}, 32'h0);
  endtask

  task report_and_stop;
    $display("errors %0d checks %0d", num_errors, total_checks);
    if (num_errors == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // ****************************************
  // Clock, watchdog and tests
  // ****************************************
  initial begin
    pclk = 1'h0;
    forever #50 pclk = ~pclk;
  end

  // Cut a hang short
  initial begin
    #10000000;
    num_errors++;
    report_and_stop;
  end

  // Main sequence
  initial begin
    presetn = 1'h0;
    req = '0;
    latch5 = 1'h0;
    repeat (12) @(posedge pclk);
    presetn <= 1'h1;
    xfer(1'h0, PORT0_DIR_ADDR, 8'h00);
    check(rd, 32'h000000FF);
    check({26'h0, p0_en_n}, 32'h3F);
    xfer(1'h0, SELECT_ADDR, 8'h00);
    check(rd, 32'h0);
    check({30'h0, co_pin, bz_pin}, 32'h0);
    xfer(1'h1, PORT0_DIR_ADDR, 8'h1E);
    xfer(1'h0, PORT0_DIR_ADDR, 8'h00);
    check(rd, 32'h000000DE);
    check({26'h0, p0_en_n}, 32'h1E);
    xfer(1'h1, PORT0_DIR_ADDR, 8'h00);
    xfer(1'h0, PORT0_DIR_ADDR, 8'h00);
    check(rd, 32'h000000C0);
    check({25'h0, pin_oe_n, p0_en_n}, 32'h0);
    xfer(1'h1, SELECT_ADDR, 8'h6E);
    xfer(1'h0, SELECT_ADDR, 8'h00);
    check(rd, 32'h0000006E);
    xfer(1'h0, 16'hFF00, 8'h00);
    check({31'h0, err}, 32'h1);
    check(rd, 32'h0);
    latch5 <= 1'h1;
    @(posedge pclk);
    @(posedge pclk);
    check({31'h0, pin_o}, 32'h1);
    latch5 <= 1'h0;
    for (int k = 0; k < 8; k++) run({4'h1, 4'(k)}, 32'h64 << k);
    run(8'h18, 32'h7788);
    for (int b = 0; b < 4; b++) run({3'h4 | 3'(b), 5'h00}, 32'h64 << (10 + b));
    // Prohibited clock code keeps the pin low
    xfer(1'h1, SELECT_ADDR, 8'h09);
    xfer(1'h1, SELECT_ADDR, 8'h19);
    repeat (40) @(posedge pclk);
    check({31'h0, pin_o}, 32'h0);
    xfer(1'h1, SELECT_ADDR, 8'h00);
    report_and_stop;
  end
endmodule // testbench
`default_nettype wire
